/* inc/flash_drv_regs.svh */
// register map, field positions and reset values of the flash driver
// Notes on behaviour
// - The supply fault flag (flags bit 7) reads one only while supply monitoring is on and the supply is below threshold.
// - With the pin-function bit of config one and the aux_pin_b control bit clear, aux_pin_b is volt_mode_enable_input and a high forces voltage mode.
// - Config two picks torch (0) or LED shutdown (1) separately for pa_sync_b events, thermistor_compare trips and supply faults.
// - The alt_external_lamp bit makes aux_pin_a high before flash_trigger_input force torch without timeout, in pa_sync_a mode only.
// - The pin I/O register can turn aux_pin_a and aux_pin_b into general-purpose inputs or outputs.
// - The pin I/O thermal-output bit turns aux_pin_b, as a general-purpose output with data bit high, into an interrupt output following the LED thermal flag.
// - Config one holds light-load disable, output level, flash inhibit, thermistor mode, aux_pin_b function, sync polarity and aux_pin_a function.
// - With thermal output on and aux_pin_b a general-purpose output, the pin is pulled low while the LED thermal flag is set.
// - With its control bit clear, aux_pin_a is an active-low reset input rather than a general-purpose pin.
`ifndef FLASH_DRV_REGS_SVH
`define FLASH_DRV_REGS_SVH

`define REG_FLAGS          8'h00
`define REG_CFG_ONE        8'h01
`define REG_CFG_TWO        8'h02
`define REG_PIN_IO         8'h03
`define REG_SUPPLY_MON     8'h04

`define CFG_ONE_RESET      8'h42
`define CFG_TWO_RESET      4'h0
`define PIN_IO_RESET       7'h00
`define SUPPLY_MON_RESET   3'h0

// fixed read-back bits: ones mask, zeros mask
`define FLAGS_ONES         8'h40
`define CFG_ONE_ZEROS      8'h10
`define CFG_TWO_ONES       8'hF0
`define PIN_IO_ONES        8'h80
`define SUPPLY_MON_ONES    8'hF0
`define SUPPLY_MON_ZEROS   8'h08

// config one fields
`define C1_LIGHT_LOAD_DIS  0
`define C1_LEVEL_5V        1
`define C1_FLASH_INHIBIT   2
`define C1_THERM_MODE      3
`define C1_PA_SYNC_B       5
`define C1_SYNC_POL_HIGH   6
`define C1_HW_TORCH        7
// config two fields
`define C2_SYNC_B_OFF      0
`define C2_THERM_OFF       1
`define C2_ALT_LAMP        2
`define C2_SUPPLY_OFF      3
// pin I/O fields
`define P_A_CTRL           0
`define P_A_DIR            1
`define P_A_DATA           2
`define P_B_CTRL           3
`define P_B_DIR            4
`define P_B_DATA           5
`define P_THERM_OUT        6
// flag fields
`define F_TIMEOUT          0
`define F_DIE_HOT          1
`define F_LED_FAULT        2
`define F_SYNC_A           3
`define F_SYNC_B           4
`define F_LED_HOT          5
`define F_SUPPLY           7
// supply monitor fields
`define S_ENABLE           0
`define S_LEVEL_LO         1
`define S_LEVEL_HI         2

`define I2C_ACK_SLOT       4'h8
`define I2C_ACK_DONE       4'h9

`endif

/* inc/flash_drv_pkg.sv */
// types shared by the flash driver register block
package flash_drv_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_PTR,
        I2C_WRITE,
        I2C_READ
    } i2c_state_t;
endpackage

/* hw/flash_i2c_slave.sv */
// i2c-compatible register access port for the flash driver
`timescale 1ns/100ps
`default_nettype none
`include "flash_drv_regs.svh"
module flash_i2c_slave
    import flash_drv_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary value
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    output logic       sda_oe,
    output logic       wr_stb,
    output logic       rd_stb,
    output byte_t      reg_addr,
    output byte_t      wr_data,
    input  wire byte_t rd_data
);
    logic [1:0]  scl_sy_r;
    logic [1:0]  sda_sy_r;
    logic        scl_d_r;
    logic        sda_d_r;
    i2c_state_t  state_r;
    logic [3:0]  cnt_r;
    byte_t       sh_r;
    logic        rw_r;

    wire scl_s    = scl_sy_r[1];
    wire sda_s    = sda_sy_r[1];
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start    = scl_s & scl_d_r & ~sda_s & sda_d_r;
    wire stop     = scl_s & scl_d_r & sda_s & ~sda_d_r;
    wire addr_hit = (sh_r[7:1] == DEV_ADDR);
    wire to_read  = (state_r == I2C_READ) |
                    ((state_r == I2C_ADDR) & rw_r);
    wire [2:0] bit_idx = 3'(4'h7 - cnt_r);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_sy_r <= 2'h3;
            sda_sy_r <= 2'h3;
            scl_d_r  <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            scl_sy_r <= {scl_sy_r[0], scl_in};
            sda_sy_r <= {sda_sy_r[0], sda_in};
            scl_d_r  <= scl_s;
            sda_d_r  <= sda_s;
        end
    end

    always_ff @(posedge clk) begin
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        if (!rst_n) begin
            state_r  <= I2C_IDLE;
            cnt_r    <= 4'h0;
            sh_r     <= 8'h00;
            rw_r     <= 1'b0;
            sda_oe   <= 1'b0;
            reg_addr <= 8'h00;
            wr_data  <= 8'h00;
        end else if (start) begin
            state_r <= I2C_ADDR;
            cnt_r   <= 4'h0;
            sda_oe  <= 1'b0;
        end else if (stop) begin
            state_r <= I2C_IDLE;
            sda_oe  <= 1'b0;
        end else if (state_r == I2C_IDLE) begin
            cnt_r <= 4'h0;
        end else if (scl_rise) begin
            if (cnt_r < `I2C_ACK_SLOT && state_r != I2C_READ)
                sh_r <= {sh_r[6:0], sda_s};
            // master nack ends a read burst
            if (cnt_r == `I2C_ACK_SLOT && state_r == I2C_READ && sda_s)
                state_r <= I2C_IDLE;
            cnt_r <= cnt_r + 4'h1;
        end else if (scl_fall) begin
            if (cnt_r == `I2C_ACK_SLOT) begin
                unique case (state_r)
                    I2C_ADDR: begin
                        rw_r   <= sh_r[0];
                        sda_oe <= addr_hit;
                        if (!addr_hit)
                            state_r <= I2C_IDLE;
                    end
                    I2C_PTR: begin
                        reg_addr <= sh_r;
                        sda_oe   <= 1'b1;
                    end
                    I2C_WRITE: begin
                        wr_data <= sh_r;
                        wr_stb  <= 1'b1;
                        sda_oe  <= 1'b1;
                    end
                    I2C_READ: begin
                        sda_oe   <= 1'b0;
                        reg_addr <= reg_addr + 8'h01;
                    end
                    default: sda_oe <= 1'b0;
                endcase
            end else if (cnt_r == `I2C_ACK_DONE) begin
                cnt_r <= 4'h0;
                // reads step at their ack slot, before the next snapshot
                if (state_r == I2C_WRITE)
                    reg_addr <= reg_addr + 8'h01;
                if (state_r == I2C_ADDR)
                    state_r <= rw_r ? I2C_READ : I2C_PTR;
                else if (state_r == I2C_PTR)
                    state_r <= I2C_WRITE;
                if (to_read) begin
                    sh_r   <= rd_data;
                    rd_stb <= 1'b1;
                    sda_oe <= ~rd_data[7];
                end else begin
                    sda_oe <= 1'b0;
                end
            end else if (state_r == I2C_READ) begin
                sda_oe <= ~sh_r[bit_idx];
            end
        end
    end
endmodule // flash_i2c_slave
`default_nettype wire

/* hw/flash_driver_fault_config_regs.sv */
// flag, configuration and pin I/O registers of the flash LED driver
`timescale 1ns/100ps
`default_nettype none
`include "flash_drv_regs.svh"
module flash_driver_fault_config_regs
    import flash_drv_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary value
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    output logic       sda_out,
    output logic       sda_oe,
    input  wire logic  flash_trigger_input,
    input  wire logic  aux_pin_a_in,
    output logic       aux_pin_a_out,
    output logic       aux_pin_a_oe,
    input  wire logic  aux_pin_b_in,
    output logic       aux_pin_b_out,
    output logic       aux_pin_b_oe,
    input  wire logic  supply_below_threshold,
    input  wire logic  thermistor_below_trip,
    input  wire logic  led_open_short,
    input  wire logic  die_over_temp,
    input  wire logic  flash_timeout_expired,
    output logic       pulse_skip_allow,
    output logic       output_5v_select,
    output logic       thermistor_mode,
    output logic       supply_monitor_on,
    output logic [1:0] supply_level_sel,
    output logic       volt_mode_force,
    output logic       flash_enable,
    output logic       hw_torch_enable,
    output logic       force_torch,
    output logic       force_shutdown,
    output logic       torch_no_timeout,
    output logic       pin_reset_n
);
    ////////////////////////////////////////////////////////////////////////
    // register access port
    wire   wr_stb;
    wire   rd_stb;
    byte_t reg_addr;
    byte_t wr_data;
    byte_t rd_data;

    flash_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_port (
        .clk      (clk),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe   (sda_oe),
        .wr_stb   (wr_stb),
        .rd_stb   (rd_stb),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .rd_data  (rd_data)
    );

    function automatic byte_t fix_bits(byte_t val, byte_t ones, byte_t zeros);
        return (val | ones) & ~zeros;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int N_IN = 8;
    logic [N_IN-1:0] sy1_r;
    logic [N_IN-1:0] sy2_r;
    logic [2:0]      prev_r;

    wire trig   = sy2_r[0];
    wire pin_a  = sy2_r[1];
    wire pin_b  = sy2_r[2];
    wire below  = sy2_r[3];
    wire trip   = sy2_r[4];
    wire led_f  = sy2_r[5];
    wire die_f  = sy2_r[6];
    wire tmo_f  = sy2_r[7];
    wire trig_rise = trig & ~prev_r[0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sy1_r  <= '0;
            sy2_r  <= '0;
            prev_r <= 3'h0;
        end else begin
            sy1_r  <= {flash_timeout_expired, die_over_temp, led_open_short,
                       thermistor_below_trip, supply_below_threshold,
                       aux_pin_b_in, aux_pin_a_in, flash_trigger_input};
            sy2_r  <= sy1_r;
            prev_r <= sy2_r[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    byte_t      cfg1_r;
    logic [3:0] cfg2_r;
    logic [6:0] pin_r;
    logic [2:0] mon_r;
    logic [5:0] flag_r;

    wire wr_c1  = wr_stb & (reg_addr == `REG_CFG_ONE);
    wire wr_c2  = wr_stb & (reg_addr == `REG_CFG_TWO);
    wire wr_pin = wr_stb & (reg_addr == `REG_PIN_IO);
    wire wr_mon = wr_stb & (reg_addr == `REG_SUPPLY_MON);
    wire rd_flg = rd_stb & (reg_addr == `REG_FLAGS);

    wire ctrl_a   = pin_r[`P_A_CTRL];
    wire ctrl_b   = pin_r[`P_B_CTRL];
    wire dir_a    = pin_r[`P_A_DIR];
    wire dir_b    = pin_r[`P_B_DIR];
    wire therm_oe = pin_r[`P_THERM_OUT];

    // aux_pin_a: dedicated input while its control bit is clear
    wire a_sync_mode = ~ctrl_a & ~cfg1_r[`C1_HW_TORCH];
    wire b_sync_mode = ~ctrl_b & cfg1_r[`C1_PA_SYNC_B];
    wire ntc_mode    = cfg1_r[`C1_THERM_MODE];
    wire alt_lamp    = cfg2_r[`C2_ALT_LAMP];

    wire supply_fault = mon_r[`S_ENABLE] & below;
    wire b_event = b_sync_mode & (pin_b == cfg1_r[`C1_SYNC_POL_HIGH]);
    wire t_event = ntc_mode & trip;
    wire a_event = a_sync_mode & pin_a & ~alt_lamp;

    // sticky flags; a set in the cycle of a read-clear survives
    logic [5:0] flag_set;
    assign flag_set[`F_TIMEOUT]   = tmo_f;
    assign flag_set[`F_DIE_HOT]   = die_f;
    assign flag_set[`F_LED_FAULT] = led_f;
    assign flag_set[`F_SYNC_A]    = a_sync_mode & (pin_a != prev_r[1]);
    assign flag_set[`F_SYNC_B]    = b_sync_mode & (pin_b != prev_r[2]);
    assign flag_set[`F_LED_HOT]   = t_event;
    wire [5:0] flag_nxt = flag_set | (flag_r & ~{6{rd_flg}});

    // gpio data bits read the pin while the pin is an input
    wire [6:0] pin_view = {pin_r[6], dir_b ? pin_r[5] : pin_b, pin_r[4:3],
                           dir_a ? pin_r[2] : pin_a, pin_r[1:0]};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg1_r <= `CFG_ONE_RESET;
            cfg2_r <= `CFG_TWO_RESET;
            pin_r  <= `PIN_IO_RESET;
            mon_r  <= `SUPPLY_MON_RESET;
            flag_r <= 6'h00;
        end else begin
            if (wr_c1)
                cfg1_r <= wr_data;
            if (wr_c2)
                cfg2_r <= wr_data[3:0];
            if (wr_pin)
                pin_r <= wr_data[6:0];
            if (wr_mon)
                mon_r <= wr_data[2:0];
            flag_r <= flag_nxt;
        end
    end

    // read mux; unmapped addresses read zero
    wire byte_t flags_view = fix_bits({supply_fault, 1'b0, flag_r},
                                      `FLAGS_ONES, 8'h00);
    assign rd_data =
        (reg_addr == `REG_FLAGS)      ? flags_view :
        (reg_addr == `REG_CFG_ONE)    ? fix_bits(cfg1_r, 8'h00,
                                                 `CFG_ONE_ZEROS) :
        (reg_addr == `REG_CFG_TWO)    ? fix_bits({4'h0, cfg2_r},
                                                 `CFG_TWO_ONES, 8'h00) :
        (reg_addr == `REG_PIN_IO)     ? fix_bits({1'b0, pin_view},
                                                 `PIN_IO_ONES, 8'h00) :
        (reg_addr == `REG_SUPPLY_MON) ? fix_bits({5'h00, mon_r},
                                                 `SUPPLY_MON_ONES,
                                                 `SUPPLY_MON_ZEROS) :
        8'h00;

    ////////////////////////////////////////////////////////////////////////
    // pin and mode outputs, all registered
    wire sh_sel_b = cfg2_r[`C2_SYNC_B_OFF];
    wire sh_sel_t = cfg2_r[`C2_THERM_OFF];
    wire sh_sel_s = cfg2_r[`C2_SUPPLY_OFF];

    wire torch_nxt = (b_event & ~sh_sel_b) | (t_event & ~sh_sel_t) |
                     (supply_fault & ~sh_sel_s) | a_event;
    wire shut_nxt  = (b_event & sh_sel_b) | (t_event & sh_sel_t) |
                     (supply_fault & sh_sel_s);
    wire trig_ok   = trig & ~cfg1_r[`C1_FLASH_INHIBIT];

    // lamp stays on only while aux_pin_a holds high
    wire alt_arm   = alt_lamp & a_sync_mode & pin_a & prev_r[1] &
                     trig_rise & ~cfg1_r[`C1_FLASH_INHIBIT];
    wire ntt_nxt   = alt_arm | (torch_no_timeout & alt_lamp &
                                a_sync_mode & pin_a);

    wire a_oe_nxt  = ctrl_a & dir_a;
    wire b_oe_nxt  = ctrl_b & dir_b;
    // thermal interrupt overrides the data bit and pulls low
    wire b_out_nxt = pin_r[`P_B_DATA] &
                     ~(therm_oe & flag_r[`F_LED_HOT]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sda_out           <= 1'b0;
            aux_pin_a_out     <= 1'b0;
            aux_pin_a_oe      <= 1'b0;
            aux_pin_b_out     <= 1'b0;
            aux_pin_b_oe      <= 1'b0;
            pulse_skip_allow  <= 1'b1;
            output_5v_select  <= 1'b1;
            thermistor_mode   <= 1'b0;
            supply_monitor_on <= 1'b0;
            supply_level_sel  <= 2'h0;
            volt_mode_force   <= 1'b0;
            flash_enable      <= 1'b0;
            hw_torch_enable   <= 1'b0;
            force_torch       <= 1'b0;
            force_shutdown    <= 1'b0;
            torch_no_timeout  <= 1'b0;
            pin_reset_n       <= 1'b1;
        end else begin
            sda_out           <= 1'b0;
            aux_pin_a_out     <= pin_r[`P_A_DATA];
            aux_pin_a_oe      <= a_oe_nxt;
            aux_pin_b_out     <= b_out_nxt;
            aux_pin_b_oe      <= b_oe_nxt;
            pulse_skip_allow  <= ~cfg1_r[`C1_LIGHT_LOAD_DIS];
            output_5v_select  <= cfg1_r[`C1_LEVEL_5V];
            thermistor_mode   <= ntc_mode;
            supply_monitor_on <= mon_r[`S_ENABLE];
            supply_level_sel  <= mon_r[`S_LEVEL_HI:`S_LEVEL_LO];
            volt_mode_force   <= ~ctrl_b & ~cfg1_r[`C1_PA_SYNC_B] &
                                 pin_b;
            flash_enable      <= trig_ok;
            hw_torch_enable   <= ~ctrl_a & cfg1_r[`C1_HW_TORCH] & pin_a;
            force_torch       <= torch_nxt | ntt_nxt;
            force_shutdown    <= shut_nxt;
            torch_no_timeout  <= ntt_nxt;
            pin_reset_n       <= ctrl_a | pin_a;
        end
    end
endmodule // flash_driver_fault_config_regs
`default_nettype wire

/* tb/flash_drv_chk.sv */
// port assertions for the flash driver register block
`timescale 1ns/100ps
`default_nettype none
module flash_drv_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_oe,
    input wire logic flash_trigger_input,
    input wire logic aux_pin_a_in,
    input wire logic aux_pin_a_oe,
    input wire logic aux_pin_b_in,
    input wire logic aux_pin_b_oe,
    input wire logic pulse_skip_allow,
    input wire logic output_5v_select,
    input wire logic thermistor_mode,
    input wire logic supply_monitor_on,
    input wire logic volt_mode_force,
    input wire logic flash_enable,
    input wire logic hw_torch_enable,
    input wire logic force_torch,
    input wire logic torch_no_timeout,
    input wire logic pin_reset_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // four samples cover the two-stage sync plus output register
    sequence pin_a_low;
        !aux_pin_a_in [*4];
    endsequence
    sequence pin_a_gone;
        pin_a_low ##1 !aux_pin_a_in;
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_flash_gate: assert property (
        !flash_trigger_input [*4] |-> !flash_enable)
        else $error("flash enable without trigger");
    a_volt_pin: assert property (
        !aux_pin_b_in [*4] |-> !volt_mode_force)
        else $error("voltage mode without pin b high");
    a_hw_torch: assert property (
        pin_a_low |-> !hw_torch_enable)
        else $error("hardware torch without pin a high");
    a_reset_pin: assert property (
        aux_pin_a_in [*4] |-> pin_reset_n)
        else $error("reset indication with pin a high");
    a_lamp_release: assert property (
        pin_a_gone |-> !torch_no_timeout)
        else $error("lamp latch held after pin a low");
    a_lamp_torch: assert property (
        torch_no_timeout && $past(torch_no_timeout) |-> force_torch)
        else $error("lamp latch without torch");
    // config outputs move only inside a write, scl low
    a_cfg_write: assert property (
        $changed(output_5v_select) || $changed(thermistor_mode) ||
        $changed(pulse_skip_allow) || $changed(supply_monitor_on)
        |-> !$past(scl_in) && !$past(scl_in, 2))
        else $error("config output moved outside a write");
    a_gpio_a: assert property (
        aux_pin_a_oe && $past(aux_pin_a_oe) |-> pin_reset_n)
        else $error("pin a output but reset indicated");
    a_gpio_b: assert property (
        aux_pin_b_oe && $past(aux_pin_b_oe) |-> !volt_mode_force)
        else $error("pin b output but voltage mode");
    a_ack_edge: assert property (
        $rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("sda pulled while scl high");
endmodule // flash_drv_chk
bind flash_driver_fault_config_regs flash_drv_chk chk (.*);
`default_nettype wire

/* tb/i2c_host_model.sv */
// i2c host model reaching the register port
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model
    import flash_drv_pkg::*;
#(
    parameter logic [6:0] ADDR = 7'h2A  // arbitrary value
) (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // sda moves mid low phase, after the device's 3-clock answer
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        sda_drv = b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda_line;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic xfer(input byte_t d, input logic m, output byte_t q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(m, ack);
    endtask
    task automatic start();
        tick(4);
        sda_drv = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(4);
    endtask
    task automatic wr(input logic [6:0] dev, input byte_t a, input byte_t d,
                      output logic ok);
        byte_t x;
        logic  k0, k1, k2;
        start();
        xfer({dev, 1'b0}, 1'b1, x, k0);
        xfer(a, 1'b1, x, k1);
        xfer(d, 1'b1, x, k2);
        stop();
        ok = !(k0 | k1 | k2);
    endtask
    task automatic rd(input byte_t a, output byte_t q, output logic ok);
        byte_t x;
        logic  k0, k1, k2, k3;
        start();
        xfer({ADDR, 1'b0}, 1'b1, x, k0);
        xfer(a, 1'b1, x, k1);
        start();
        xfer({ADDR, 1'b1}, 1'b1, x, k2);
        // single byte, nacked to end the read
        xfer(8'hFF, 1'b1, q, k3);
        stop();
        ok = !(k0 | k1 | k2);
    endtask
endmodule // i2c_host_model
`default_nettype wire

/* tb/flash_driver_fault_config_regs_test.sv */
// self-checking bench for the flash driver register block
`timescale 1ns/100ps
`default_nettype none
`include "flash_drv_regs.svh"
module flash_driver_fault_config_regs_test
    import flash_drv_pkg::*;
;
    localparam logic [6:0] DEV = 7'h2A;  // arbitrary value
    logic clk = 1'b0, rst_n = 1'b0, flash_trigger_input = 1'b0;
    logic a_ext = 1'b0, b_ext = 1'b0, supply_below_threshold = 1'b0;
    logic thermistor_below_trip = 1'b0, led_open_short = 1'b0;
    logic die_over_temp = 1'b0, flash_timeout_expired = 1'b0;
    logic scl_in, sda_drv, sda_out, sda_oe, aux_pin_a_out, aux_pin_a_oe;
    logic aux_pin_b_out, aux_pin_b_oe, pulse_skip_allow, output_5v_select;
    logic thermistor_mode, supply_monitor_on, volt_mode_force, flash_enable;
    logic hw_torch_enable, force_torch, force_shutdown, torch_no_timeout;
    logic       pin_reset_n;
    logic [1:0] supply_level_sel;
    int         num_errors = 0, checks = 0, seed = 33;
    // pull-up on sda; shared pins follow whoever enables
    wire logic  sda_w = sda_drv & ~sda_oe;
    wire logic  a_w = aux_pin_a_oe ? aux_pin_a_out : a_ext;
    wire logic  b_w = aux_pin_b_oe ? aux_pin_b_out : b_ext;
    always #25 clk = ~clk;
    flash_driver_fault_config_regs #(.DEV_ADDR(DEV)) uut (.sda_in(sda_w),
        .aux_pin_a_in(a_w), .aux_pin_b_in(b_w), .*);
    i2c_host_model #(.ADDR(DEV)) host (.clk(clk), .sda_line(sda_w),
        .scl(scl_in), .sda_drv(sda_drv));
    ////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input byte_t a, input byte_t d);
        logic ok;
        host.wr(DEV, a, d, ok);
        chk(ok, 1'b1);
    endtask
    task automatic rdc(input byte_t a, input byte_t exp);
        byte_t q;
        logic  ok;
        host.rd(a, q, ok);
        chk(ok, 1'b1);
        chk(q, exp);
    endtask
    function automatic byte_t cfg_one_exp(byte_t v);
        return v & 8'hEF;
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial begin
        byte_t v, q;
        logic  ok;
        byte_t c1 [3] = '{8'h62, 8'h4A, 8'h42};
        byte_t fl [3] = '{8'h50, 8'h60, 8'hC0};
        int    bt [3] = '{0, 1, 3};
        tick(5);
        rst_n = 1'b1;
        tick(3);
        rdc(`REG_FLAGS, 8'h40);
        rdc(`REG_CFG_ONE, 8'h42);
        rdc(`REG_CFG_TWO, 8'hF0);
        rdc(`REG_PIN_IO, 8'h80);
        chk({pulse_skip_allow, output_5v_select, sda_out}, 3'b110);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'hFF : byte_t'($random(seed));
            wr(`REG_CFG_ONE, v);
            rdc(`REG_CFG_ONE, cfg_one_exp(v));
            chk({pulse_skip_allow, output_5v_select, thermistor_mode},
                {~v[0], v[1], v[3]});
        end
        host.wr(7'h2B, `REG_CFG_ONE, 8'h42, ok);
        chk(ok, 1'b0);
        flash_trigger_input = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(`REG_CFG_ONE, {5'h08, k[0], 2'h2});
            tick(4);
            chk(flash_enable, !k[0]);
        end
        flash_trigger_input = 1'b0;
        $display("test config one done");
        wr(`REG_CFG_ONE, 8'h42);
        b_ext = 1'b1;
        tick(4);
        chk(volt_mode_force, 1'b1);
        b_ext = 1'b0;
        host.rd(`REG_FLAGS, q, ok);
        // one event at a time, torch then shutdown response
        for (int e = 0; e < 3; e++) begin
            wr(`REG_CFG_ONE, c1[e]);
            wr(`REG_SUPPLY_MON, {7'h00, e == 2});
            {b_ext, thermistor_below_trip, supply_below_threshold} =
                3'b100 >> e;
            for (int s = 0; s < 2; s++) begin
                wr(`REG_CFG_TWO, 8'(s << bt[e]));
                chk({force_torch, force_shutdown}, {!s[0], s[0]});
            end
            chk({supply_monitor_on, volt_mode_force}, {e == 2, 1'b0});
            rdc(`REG_FLAGS, fl[e]);
            {b_ext, thermistor_below_trip, supply_below_threshold} = 3'b000;
            wr(`REG_CFG_TWO, 8'h00);
            host.rd(`REG_FLAGS, q, ok);
            rdc(`REG_FLAGS, 8'h40);
        end
        wr(`REG_SUPPLY_MON, 8'h06);
        rdc(`REG_SUPPLY_MON, 8'hF6);
        chk({supply_monitor_on, supply_level_sel}, 3'b011);
        supply_below_threshold = 1'b1;
        rdc(`REG_FLAGS, 8'h40);
        supply_below_threshold = 1'b0;
        for (int i = 0; i < 3; i++) begin
            {led_open_short, die_over_temp, flash_timeout_expired} =
                3'b100 >> i;
            tick(6);
            {led_open_short, die_over_temp, flash_timeout_expired} = 3'b000;
            tick(6);
            rdc(`REG_FLAGS, 8'h40 | (8'h04 >> i));
        end
        $display("test events done");
        wr(`REG_CFG_ONE, 8'h4A);
        thermistor_below_trip = 1'b1;
        wr(`REG_PIN_IO, 8'h78);
        chk({aux_pin_b_oe, aux_pin_b_out}, 2'b10);
        thermistor_below_trip = 1'b0;
        host.rd(`REG_FLAGS, q, ok);
        tick(4);
        chk({aux_pin_b_oe, aux_pin_b_out}, 2'b11);
        wr(`REG_PIN_IO, 8'h00);
        chk(pin_reset_n, 1'b0);
        wr(`REG_PIN_IO, 8'h07);
        chk({aux_pin_a_oe, aux_pin_a_out, pin_reset_n}, 3'b111);
        wr(`REG_PIN_IO, 8'h00);
        $display("test pins done");
        wr(`REG_CFG_ONE, 8'h42);
        // pin a leads the trigger; only the lamp bit latches
        for (int k = 0; k < 2; k++) begin
            wr(`REG_CFG_TWO, {5'h00, k[0], 2'h0});
            a_ext = 1'b1;
            tick(4);
            chk(pin_reset_n, 1'b1);
            flash_trigger_input = 1'b1;
            tick(6);
            chk({torch_no_timeout, force_torch}, {k[0], 1'b1});
            a_ext = 1'b0;
            flash_trigger_input = 1'b0;
            tick(6);
        end
        rdc(`REG_FLAGS, 8'h48);
        a_ext = 1'b1;
        wr(`REG_CFG_ONE, 8'hC2);
        chk(hw_torch_enable, 1'b1);
        a_ext = 1'b0;
        $display("test lamp done");
        complete_run();
    end
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule // flash_driver_fault_config_regs_test
`default_nettype wire
